// ==== hdl/tcm_emu.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcm_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // Pointers and flags; flags are registered so in_ready_out and out_valid_out are flops
  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      in_ready_out <= (cnt_d != FULL_CNT);
      out_valid_out <= (cnt_d != '0);
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  assign out_data_out = mem_q[rd_q];
endmodule : tcm_fifo

module tcm_emu #(
  parameter int POLL_CYC = tcm_pkg::POLL_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Mailbox link to the target
  tcm_mbx_if.emu mbx,
  // Mode control
  input wire logic mode_start_in,
  input wire logic [tcm_pkg::ADDR_W-1:0] base_addr_in,
  output logic mode_active_out,
  // Target status
  input wire logic target_running_in,
  input wire logic break_in,
  input wire logic error_in,
  output logic report_valid_out,
  output logic [tcm_pkg::RPT_W-1:0] report_code_out,
  // Controlling port, characters arriving
  input wire logic port_rx_valid_in,
  input wire logic [tcm_pkg::CHAR_W-1:0] port_rx_char_in,
  output logic port_rx_ready_out,
  // Controlling port, characters leaving
  output logic port_tx_valid_out,
  output logic [tcm_pkg::CHAR_W-1:0] port_tx_char_out
);
  localparam int TW = $clog2(POLL_CYC + 1);
  localparam int HW = tcm_pkg::HALT_W;
  localparam int CHW = tcm_pkg::CHAR_W;
  localparam int FB = tcm_pkg::FLAG_BIT;
  localparam logic [TW-1:0] POLL_LOAD = TW'(POLL_CYC - 1);
  localparam logic [HW-1:0] HALT_LOAD = HW'(tcm_pkg::HALT_CYC - 1);

  tcm_pkg::tcm_state_t st_q, st_d;
  tcm_pkg::tcm_op_t op_q, op_d;
  logic active_q, active_d, esc_q, esc_d;
  logic [tcm_pkg::ADDR_W-1:0] base_q, base_d;
  logic [tcm_pkg::RPT_W-1:0] stop_q, stop_d, rpt_code_d;
  logic rpt_valid_d, tx_valid_d;
  logic [CHW-1:0] tx_char_d;
  logic [TW-1:0] timer_q, timer_d;
  logic [HW-1:0] hcnt_q, hcnt_d;
  logic [tcm_pkg::BYTE_W-1:0] rd_q, rd_d;
  logic req_d, we_d, halt_d;
  logic [tcm_pkg::ADDR_W-1:0] addr_d;
  logic [tcm_pkg::BYTE_W-1:0] wdata_d;
  logic take, is_esc, push, pop, fifo_valid, fifo_ready;
  logic [CHW-1:0] fifo_char;

  // Inbound characters queue here until the sequencer is free
  tcm_fifo #(
    .WIDTH(CHW),
    .DEPTH(tcm_pkg::FIFO_DEPTH)
  ) u_tcm_fifo (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(push),
    .in_data_in(port_rx_char_in),
    .in_ready_out(fifo_ready),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_char),
    .out_ready_in(pop)
  );

  // Mode, escape detection and the access sequencer
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    active_d = active_q;
    esc_d = esc_q;
    base_d = base_q;
    stop_d = stop_q;
    rpt_valid_d = 1'b0;
    rpt_code_d = report_code_out;
    tx_valid_d = 1'b0;
    tx_char_d = port_tx_char_out;
    timer_d = timer_q;
    hcnt_d = hcnt_q;
    rd_d = rd_q;
    req_d = mbx.req;
    we_d = mbx.we;
    halt_d = mbx.halt;
    addr_d = mbx.addr;
    wdata_d = mbx.wdata;
    pop = 1'b0;
    take = port_rx_valid_in && port_rx_ready_out;
    is_esc = (port_rx_char_in == tcm_pkg::ESC_CHAR);
    // Second escape is swallowed, the first passes to the target
    push = take && active_q && !(is_esc && esc_q);
    if (mode_start_in && !active_q) begin
      active_d = 1'b1;
      base_d = base_addr_in;
      stop_d = '0;
      esc_d = 1'b0;
    end
    if (take && active_q) begin
      esc_d = is_esc && !esc_q;
      if (is_esc && esc_q) begin
        active_d = 1'b0;
        rpt_valid_d = 1'b1;
        rpt_code_d = stop_q;
      end
    end
    if (active_q && !target_running_in) begin
      stop_d[tcm_pkg::RPT_BRK] = stop_q[tcm_pkg::RPT_BRK] | break_in;
      stop_d[tcm_pkg::RPT_ERR] = stop_q[tcm_pkg::RPT_ERR] | error_in;
    end
    case (st_q)
      tcm_pkg::ST_IDLE: begin
        timer_d = POLL_LOAD;
        if (active_q) begin
          st_d = tcm_pkg::ST_WAIT;
        end
      end
      tcm_pkg::ST_WAIT: begin
        if (!active_q) begin
          st_d = tcm_pkg::ST_IDLE;
        end else if (target_running_in) begin
          if (fifo_valid) begin
            // No look at the inbound flag before overwriting
            pop = 1'b1;
            op_d = tcm_pkg::OP_WR;
            we_d = 1'b1;
            addr_d = tcm_pkg::ADDR_W'(base_q + tcm_pkg::IN_OFS);
            wdata_d = {1'b1, fifo_char};
            req_d = 1'b1;
            halt_d = 1'b1;
            hcnt_d = HALT_LOAD;
            st_d = tcm_pkg::ST_ACC;
          end else if (timer_q == '0) begin
            op_d = tcm_pkg::OP_RD;
            we_d = 1'b0;
            addr_d = tcm_pkg::ADDR_W'(base_q + tcm_pkg::OUT_OFS);
            req_d = 1'b1;
            halt_d = 1'b1;
            hcnt_d = HALT_LOAD;
            st_d = tcm_pkg::ST_ACC;
          end else begin
            timer_d = TW'(timer_q - 1'b1);
          end
        end
      end
      tcm_pkg::ST_ACC: begin
        if (hcnt_q != '0) begin
          hcnt_d = HW'(hcnt_q - 1'b1);
        end
        if (mbx.ack) begin
          req_d = 1'b0;
          if (op_q == tcm_pkg::OP_RD) begin
            rd_d = mbx.rdata;
          end
          st_d = tcm_pkg::ST_HOLD;
        end
      end
      tcm_pkg::ST_HOLD: begin
        if (hcnt_q != '0) begin
          hcnt_d = HW'(hcnt_q - 1'b1);
        end else begin
          halt_d = 1'b0;
          st_d = tcm_pkg::ST_WAIT;
          case (op_q)
            tcm_pkg::OP_RD: begin
              if (rd_q[FB]) begin
                // Zero the location before forwarding
                op_d = tcm_pkg::OP_CLR;
                we_d = 1'b1;
                wdata_d = tcm_pkg::BYTE_RST;
                req_d = 1'b1;
                halt_d = 1'b1;
                hcnt_d = HALT_LOAD;
                st_d = tcm_pkg::ST_ACC;
              end else begin
                timer_d = POLL_LOAD;
              end
            end
            tcm_pkg::OP_CLR: begin
              tx_valid_d = 1'b1;
              tx_char_d = rd_q[CHW-1:0];
              timer_d = '0;
            end
            default: begin
              timer_d = timer_q;
            end
          endcase
        end
      end
      default: begin
        st_d = tcm_pkg::ST_IDLE;
        halt_d = 1'b0;
        req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= tcm_pkg::ST_IDLE;
      op_q <= tcm_pkg::OP_RD;
      active_q <= 1'b0;
      esc_q <= 1'b0;
      base_q <= '0;
      stop_q <= '0;
      timer_q <= '0;
      hcnt_q <= '0;
      rd_q <= tcm_pkg::BYTE_RST;
      mbx.req <= 1'b0;
      mbx.we <= 1'b0;
      mbx.halt <= 1'b0;
      mbx.addr <= '0;
      mbx.wdata <= tcm_pkg::BYTE_RST;
      mode_active_out <= 1'b0;
      report_valid_out <= 1'b0;
      report_code_out <= '0;
      port_tx_valid_out <= 1'b0;
      port_tx_char_out <= '0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      active_q <= active_d;
      esc_q <= esc_d;
      base_q <= base_d;
      stop_q <= stop_d;
      timer_q <= timer_d;
      hcnt_q <= hcnt_d;
      rd_q <= rd_d;
      mbx.req <= req_d;
      mbx.we <= we_d;
      mbx.halt <= halt_d;
      mbx.addr <= addr_d;
      mbx.wdata <= wdata_d;
      mode_active_out <= active_d;
      report_valid_out <= rpt_valid_d;
      report_code_out <= rpt_code_d;
      port_tx_valid_out <= tx_valid_d;
      port_tx_char_out <= tx_char_d;
    end
  end

  // Ready is the buffer's own registered flag
  assign port_rx_ready_out = fifo_ready;
endmodule : tcm_emu
`default_nettype wire

// ==== include/tcm_pkg.sv ====
package tcm_pkg;
  // Clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int POLL_TIME_MS = 500;
  localparam int POLL_CYC = CLK_HZ / 1000 * POLL_TIME_MS;
  localparam int HALT_TIME_US = 100;
  localparam int HALT_CYC = CLK_HZ / 1_000_000 * HALT_TIME_US;
  localparam int HALT_W = $clog2(HALT_CYC + 1);
  // Mailbox layout
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int CHAR_W = 7;
  localparam int FLAG_BIT = 7;
  localparam logic [ADDR_W-1:0] OUT_OFS = 16'h0000;
  localparam logic [ADDR_W-1:0] IN_OFS = 16'h0001;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  // Escape character, sent twice to leave the mode
  localparam logic [CHAR_W-1:0] ESC_CHAR = 7'h1B;
  // Inbound buffer
  localparam int FIFO_DEPTH = 8;
  // Stop report bits
  localparam int RPT_W = 2;
  localparam int RPT_BRK = 0;
  localparam int RPT_ERR = 1;
  // Emulator end sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_ACC = 4'h4,
    ST_HOLD = 4'h8
  } tcm_state_t;
  // Kind of memory access in flight
  typedef enum logic [1:0] {
    OP_RD = 2'h0,
    OP_CLR = 2'h1,
    OP_WR = 2'h2
  } tcm_op_t;
endpackage : tcm_pkg

// ==== include/tcm_mbx_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tcm_mbx_if;
  logic req;
  logic we;
  logic halt;
  logic [tcm_pkg::ADDR_W-1:0] addr;
  logic [tcm_pkg::BYTE_W-1:0] wdata;
  logic ack;
  logic [tcm_pkg::BYTE_W-1:0] rdata;
  modport emu (output req, we, halt, addr, wdata, input ack, rdata);
  modport tgt (input req, we, halt, addr, wdata, output ack, rdata);
endinterface : tcm_mbx_if
`default_nettype wire

// ==== hdl/tcm_tgt.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcm_tgt (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Mailbox link to the emulator
  tcm_mbx_if.tgt mbx,
  // Mailbox placement and options
  input wire logic [tcm_pkg::ADDR_W-1:0] base_addr_in,
  input wire logic echo_en_in,
  // Program output characters
  input wire logic tx_valid_in,
  input wire logic [tcm_pkg::CHAR_W-1:0] tx_char_in,
  output logic tx_ready_out,
  // Program input characters
  output logic rx_valid_out,
  output logic [tcm_pkg::CHAR_W-1:0] rx_char_out
);
  localparam int FB = tcm_pkg::FLAG_BIT;
  localparam int CHW = tcm_pkg::CHAR_W;
  logic [tcm_pkg::BYTE_W-1:0] out_q, out_d, in_q, in_d, rdata_d;
  logic ack_d, tx_rdy_d, rx_valid_d;
  logic [CHW-1:0] rx_char_d;
  logic hit_out, hit_in;

  // Memory side for the emulator, then the program when not halted
  always_comb begin
    out_d = out_q;
    in_d = in_q;
    rdata_d = mbx.rdata;
    ack_d = 1'b0;
    tx_rdy_d = 1'b0;
    rx_valid_d = 1'b0;
    rx_char_d = rx_char_out;
    hit_out = (mbx.addr == tcm_pkg::ADDR_W'(base_addr_in + tcm_pkg::OUT_OFS));
    hit_in = (mbx.addr == tcm_pkg::ADDR_W'(base_addr_in + tcm_pkg::IN_OFS));
    if (mbx.req && !mbx.ack) begin
      ack_d = 1'b1;
      rdata_d = hit_out ? out_q : (hit_in ? in_q : tcm_pkg::BYTE_RST);
      if (mbx.we && hit_out) begin
        out_d = mbx.wdata;
      end
      if (mbx.we && hit_in) begin
        in_d = mbx.wdata;
      end
    end else if (!mbx.halt) begin
      if (in_q[FB]) begin
        rx_valid_d = 1'b1;
        rx_char_d = in_q[CHW-1:0];
        in_d = {1'b0, in_q[CHW-1:0]};
        if (echo_en_in) begin
          out_d = in_q;
        end
      end else if (tx_valid_in && !out_q[FB]) begin
        out_d = {1'b1, tx_char_in};
        tx_rdy_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_q <= tcm_pkg::BYTE_RST;
      in_q <= tcm_pkg::BYTE_RST;
      mbx.ack <= 1'b0;
      mbx.rdata <= tcm_pkg::BYTE_RST;
      tx_ready_out <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_char_out <= '0;
    end else begin
      out_q <= out_d;
      in_q <= in_d;
      mbx.ack <= ack_d;
      mbx.rdata <= rdata_d;
      tx_ready_out <= tx_rdy_d;
      rx_valid_out <= rx_valid_d;
      rx_char_out <= rx_char_d;
    end
  end
endmodule : tcm_tgt
`default_nettype wire

// ==== tb/tcm_mbx_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcm_mbx_asserts #(
  parameter int POLL_CYC = 50
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Mailbox link signals
  input wire logic req,
  input wire logic we,
  input wire logic halt,
  input wire logic [tcm_pkg::ADDR_W-1:0] addr,
  input wire logic [tcm_pkg::BYTE_W-1:0] wdata,
  input wire logic ack,
  input wire logic [tcm_pkg::BYTE_W-1:0] rdata
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  localparam int REPOLL_MAX = 1100;
  int hcnt_q, hcnt_d, gap_q, gap_d, rp_q, rp_d;
  logic [tcm_pkg::ADDR_W-1:0] rda_q, rda_d;
  logic seen_q, seen_d, req_q;
  // Halt length, spacing since empty poll, outbound address
  always_comb begin
    hcnt_d = halt ? hcnt_q + 1 : 0;
    // Read and its clear share one halt, so count from each access start
    if (req && !req_q) hcnt_d = 1;
    gap_d = (gap_q < POLL_CYC) ? gap_q + 1 : gap_q;
    rp_d = (rp_q != 0) ? rp_q + 1 : 0;
    rda_d = rda_q;
    seen_d = seen_q;
    if (ack && !we && !rdata[tcm_pkg::FLAG_BIT]) gap_d = 0;
    // Cycles from a clear until the next outbound read starts
    if (ack && we && wdata == 8'h00) rp_d = 1;
    if (req && !req_q && !we) rp_d = 0;
    if (ack && !we) begin
      rda_d = addr;
      seen_d = 1'b1;
    end
  end
  // Saturated gap at reset, so the first poll is not judged
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hcnt_q <= 0;
      gap_q <= POLL_CYC;
      rp_q <= 0;
      req_q <= 1'b0;
      rda_q <= '0;
      seen_q <= 1'b0;
    end else begin
      hcnt_q <= hcnt_d;
      gap_q <= gap_d;
      rp_q <= rp_d;
      req_q <= req;
      rda_q <= rda_d;
      seen_q <= seen_d;
    end
  end
  // Handshake shape
  AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr)
    && $stable(we) && $stable(wdata)) else $error("request moved early");
  AST_ACK_NEXT: assert property ($rose(req) |=> ack && req)
    else $error("no answer one cycle after request");
  AST_ACK_PULSE: assert property (ack |=> !ack && !req)
    else $error("answer or request held too long");
  // Suspension around accesses
  AST_HALT_REQ: assert property (req |-> halt)
    else $error("access without suspension");
  AST_HALT_LEN: assert property (
    $fell(halt) |-> hcnt_q inside {[999:1001]})
    else $error("suspension length wrong");
  // Byte contents and placement
  AST_IN_FLAG: assert property (
    req && we && wdata != 8'h00 |-> wdata[tcm_pkg::FLAG_BIT])
    else $error("inbound flag clear");
  AST_CLR_ADDR: assert property (
    $rose(req) && we && wdata == 8'h00 |-> seen_q && addr == rda_q)
    else $error("clear at wrong byte");
  AST_IN_ADDR: assert property (
    $rose(req) && we && wdata[7] && seen_q |-> addr == rda_q + 16'h0001)
    else $error("inbound byte misplaced");
  // Poll timing; long window kept in a counter, not a delay range
  AST_REPOLL: assert property (rp_q <= REPOLL_MAX)
    else $error("no prompt re-read");
  AST_POLL_GAP: assert property (
    $rose(req) && !we |-> gap_q == POLL_CYC)
    else $error("poll too soon");
  // Main scenarios reached
  COV_FLAGGED: cover property (ack && !we && rdata[tcm_pkg::FLAG_BIT]);
  COV_INBOUND: cover property ($rose(req) && we && wdata[7]);
  COV_HALT_END: cover property ($fell(halt));
endmodule : tcm_mbx_asserts
`default_nettype wire

// ==== tb/target_char_mailbox_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module target_char_mailbox_bench;
  localparam int POLL = 3000;
  localparam logic [6:0] ESC = tcm_pkg::ESC_CHAR;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic start, running, brk, err, echo, rx_v, tx_v;
  logic active, rpt_v, rdy, ptx_v, txr, rxv;
  logic [1:0] rpt_c;
  logic [15:0] base;
  logic [6:0] rx_c, tx_c, ptx_c, rxc;
  logic [6:0] exp_tx[$], exp_rx[$];
  int errors, checks, seed;
  tcm_mbx_if mbx_if ();
  tcm_emu #(.POLL_CYC(POLL)) u_tcm_emu (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .mbx(mbx_if.emu), .mode_start_in(start),
    .base_addr_in(base), .mode_active_out(active),
    .target_running_in(running), .break_in(brk), .error_in(err),
    .report_valid_out(rpt_v), .report_code_out(rpt_c),
    .port_rx_valid_in(rx_v), .port_rx_char_in(rx_c),
    .port_rx_ready_out(rdy), .port_tx_valid_out(ptx_v),
    .port_tx_char_out(ptx_c));
  tcm_tgt u_tcm_tgt (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .mbx(mbx_if.tgt), .base_addr_in(base), .echo_en_in(echo),
    .tx_valid_in(tx_v), .tx_char_in(tx_c), .tx_ready_out(txr),
    .rx_valid_out(rxv), .rx_char_out(rxc));
  tcm_mbx_asserts #(.POLL_CYC(POLL)) u_tcm_mbx_asserts (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .req(mbx_if.req), .we(mbx_if.we),
    .halt(mbx_if.halt), .addr(mbx_if.addr), .wdata(mbx_if.wdata),
    .ack(mbx_if.ack), .rdata(mbx_if.rdata));
  // Clock, 100 ns period
  always #50 mclk_in = ~mclk_in;
  task conclude;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task automatic fail(input string m);
    errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail
  task automatic chk_char(input logic [6:0] g, input logic [6:0] e);
    checks++;
    if (g !== e) fail("character mismatch");
  endtask : chk_char
  task automatic chk_num(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) fail("value mismatch");
  endtask : chk_num
  // Random character, never the escape code
  function automatic logic [6:0] rnd();
    logic [6:0] r;
    r = 7'($random(seed));
    if (r == ESC) r = 7'h41;
    return r;
  endfunction : rnd
  task start_mode;
    @(posedge mclk_in) start <= 1'b1;
    @(posedge mclk_in) start <= 1'b0;
    @(negedge mclk_in) chk_num(8'(active), 8'h01);
  endtask : start_mode
  // Offer one port character; ok tells whether it was taken
  task push(input logic [6:0] c, input int lim, output bit ok);
    int i;
    ok = 1'b0;
    @(posedge mclk_in);
    rx_v <= 1'b1;
    rx_c <= c;
    for (i = 0; i < lim && !ok; i++) begin
      @(negedge mclk_in);
      ok = rdy;
    end
    @(posedge mclk_in) rx_v <= 1'b0;
  endtask : push
  // Program output character, held until the target stores it
  task send(input logic [6:0] c);
    int i;
    @(posedge mclk_in);
    tx_v <= 1'b1;
    tx_c <= c;
    exp_tx.push_back(c);
    for (i = 0; i < 20000 && txr !== 1'b1; i++) @(negedge mclk_in);
    if (i == 20000) fail("program send stalled");
    @(posedge mclk_in) tx_v <= 1'b0;
  endtask : send
  task waitq;
    int i;
    for (i = 0; i < 20000 && exp_tx.size() + exp_rx.size() > 0; i++)
      @(negedge mclk_in);
    if (exp_tx.size() + exp_rx.size() > 0) fail("expected output missing");
    // Callers drive inputs next, so hand back on a rising edge
    @(posedge mclk_in);
  endtask : waitq
  // Freezing mid-access is avoided: wait for a quiet spell
  task settle;
    int n;
    n = 0;
    while (n < 3) begin
      @(negedge mclk_in);
      n = mbx_if.halt ? 0 : n + 1;
    end
    @(posedge mclk_in);
  endtask : settle
  // Output monitors against the queued model
  always @(negedge mclk_in) begin
    if (ptx_v === 1'b1) begin
      if (exp_tx.size() == 0) fail("unexpected port character");
      else chk_char(ptx_c, exp_tx.pop_front());
    end
    if (rxv === 1'b1) begin
      if (exp_rx.size() == 0) fail("unexpected program character");
      else chk_char(rxc, exp_rx.pop_front());
    end
  end
  // Hang guard, well past the expected run length
  initial begin
    repeat (90000) @(posedge mclk_in);
    fail("watchdog expired");
    conclude;
  end
  initial begin
    int i, k, n;
    bit ok;
    logic [6:0] c;
    seed = 32'hDC5D;
    {errors, checks} = '0;
    {start, running, brk, err, echo, rx_v, tx_v} = '0;
    {rx_c, tx_c, base} = '0;
    repeat (4) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    base <= 16'($random(seed)) & 16'hFFFE;
    running <= 1'b1;
    start_mode;
    // Back-to-back program output
    for (i = 0; i < 3; i++) send(rnd());
    waitq;
    // Fill the inbound buffer while the target is stopped
    settle;
    running <= 1'b0;
    n = 0;
    for (i = 0; i < 10; i++) begin
      c = rnd();
      push(c, 4, ok);
      if (ok) begin
        n++;
        exp_rx.push_back(c);
      end
    end
    chk_num(8'(n), 8'(tcm_pkg::FIFO_DEPTH));
    @(posedge mclk_in) running <= 1'b1;
    waitq;
    // Echo of one received character
    echo <= 1'b1;
    c = rnd();
    exp_rx.push_back(c);
    exp_tx.push_back(c);
    push(c, 50, ok);
    waitq;
    echo <= 1'b0;
    // Exit with each nonzero stop report code (1 to 3)
    for (k = 1; k < 4; k++) begin
      if (active !== 1'b1) start_mode;
      settle;
      running <= 1'b0;
      brk <= k[0];
      err <= k[1];
      repeat (2) @(posedge mclk_in);
      {brk, err} <= 2'b00;
      running <= 1'b1;
      exp_rx.push_back(ESC);
      push(ESC, 50, ok);
      waitq;
      push(ESC, 50, ok);
      for (i = 0; i < 50 && rpt_v !== 1'b1; i++) @(negedge mclk_in);
      chk_num(8'(rpt_c), 8'(k));
      chk_num(8'(active), 8'h00);
    end
    conclude;
  end
endmodule : target_char_mailbox_bench
`default_nettype wire
